// *** hdl/mmci_pkg.sv ***
/*
 mmci_pkg: constants, states and carrier types for the main motor drive logic.
 assumes: shared by the top module, its synchroniser and the testbench checks and bench.
*/
package mmci_pkg;
   // measurement widths
   localparam int PERIOD_W = 20;
   localparam logic [PERIOD_W-1:0] PERIOD_MAX = 20'hFFFFF;
   localparam logic [PERIOD_W-1:0] PERIOD_RESET = 20'hFFFFF;
   // 6.25 percent is one sixteenth, a shift by four
   localparam int LOCK_SHIFT = 4;
   localparam int LOCK_W = 4;
   localparam logic [LOCK_W-1:0] LOCK_COUNT = 4'h8;
   localparam logic [LOCK_W-1:0] LOCK_RESET = 4'h0;
   // drive strength
   localparam int DUTY_W = 8;
   localparam logic [DUTY_W-1:0] DUTY_RESET = 8'h00;
   localparam logic [DUTY_W-1:0] DUTY_START = 8'h40;
   localparam logic [DUTY_W-1:0] DUTY_MAX = 8'hFF;
   localparam logic [DUTY_W-1:0] DUTY_MIN = 8'h00;
   // phase error accumulator
   localparam int PHASE_W = 4;
   localparam logic signed [PHASE_W-1:0] PHASE_RESET = 4'sh0;
   localparam logic signed [PHASE_W-1:0] PHASE_HI = 4'sh7;
   localparam logic signed [PHASE_W-1:0] PHASE_LO = -4'sh7;
   // reference clock divider: one reference period per this many link clocks
   localparam int REF_DIV_W = 16;
   localparam logic [REF_DIV_W-1:0] REF_DIV_DEFAULT = 16'h07D0;
   localparam logic [REF_DIV_W-1:0] REF_DIV_RESET = 16'h0000;
   localparam int SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      MMCI_STOP = 2'b00,
      MMCI_RUN = 2'b01,
      MMCI_BRAKE = 2'b11
   } mmci_state_e;

   typedef struct packed {
      logic a_hi;
      logic a_lo;
      logic b_hi;
      logic b_lo;
      logic c_hi;
      logic c_lo;
   } mmci_gate_s;

   typedef struct packed {
      logic run_n;
      logic dir_sel;
      logic brake_n;
      logic [2:0] hall;
   } mmci_ctrl_s;

   localparam mmci_gate_s GATE_OFF = 6'h00;
   localparam mmci_gate_s GATE_BRAKE = 6'h15;
   // run off, direction clockwise, brake off, no hall code
   localparam mmci_ctrl_s CTRL_RESET = 6'h28;
endpackage : mmci_pkg

// *** hdl/mmci_sync.sv ***
/*
 mmci_sync: two-stage synchroniser bank for levels entering a clock domain.
 assumes: each bit is a slow level; the first stage is read only by the second.
*/
module mmci_sync
   import mmci_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // clock and reset of the receiving domain
   input wire logic clk,
   input wire logic rst,
   // levels in and out
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] q_reg;
   logic [WIDTH-1:0] q_next;

   always_comb begin
      meta_next = d;
      q_next = meta_reg;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= INIT;
         q_reg <= INIT;
      end else begin
         meta_reg <= meta_next;
         q_reg <= q_next;
      end
   end

   assign q = q_reg;
endmodule : mmci_sync

// *** hdl/mmci_top.sv ***
/*
 mmci_top: commutation, speed lock and brake logic of the main motor driver board.
 assumes: pins arrive asynchronously; the reference clock runs free from the controller.
*/
module mmci_top
   import mmci_pkg::*;
#(
   parameter logic [REF_DIV_W-1:0] REF_DIV = REF_DIV_DEFAULT
) (
   // system clock and reset
   input wire logic CLK,
   input wire logic RST,
   // reference clock from the controller
   input wire logic MOTOR_REF_CLK,
   // commands from the controller
   input wire logic MOTOR_RUN_N,
   input wire logic MOTOR_DIR_SEL,
   input wire logic MOTOR_BRAKE_N,
   // rotor position
   input wire logic [2:0] HALL,
   // winding drive
   output mmci_gate_s GATE,
   // status to the controller
   output logic MOTOR_LOCKED_N,
   output logic SPEED_FEEDBACK_PULSE
);
   // six-step table; reversing swaps the high and low side of each step
   function automatic mmci_gate_s commutate(input logic [2:0] hall, input logic ccw,
                                            input logic pwm_on);
      logic [2:0] hi;
      logic [2:0] lo;
      mmci_gate_s g;
      hi = 3'h0;
      lo = 3'h0;
      case (hall)
         3'b101: begin hi = 3'b100; lo = 3'b010; end
         3'b100: begin hi = 3'b100; lo = 3'b001; end
         3'b110: begin hi = 3'b010; lo = 3'b001; end
         3'b010: begin hi = 3'b010; lo = 3'b100; end
         3'b011: begin hi = 3'b001; lo = 3'b100; end
         3'b001: begin hi = 3'b001; lo = 3'b010; end
         default: begin hi = 3'h0; lo = 3'h0; end
      endcase
      if (ccw) begin
         {hi, lo} = {lo, hi};
      end
      // high side chopped, low side held: keeps the current path through one switch
      if (!pwm_on) begin
         hi = 3'h0;
      end
      g.a_hi = hi[2];
      g.a_lo = lo[2];
      g.b_hi = hi[1];
      g.b_lo = lo[1];
      g.c_hi = hi[0];
      g.c_lo = lo[0];
      return g;
   endfunction : commutate

   // true when the measured period lies within one sixteenth of the reference
   function automatic logic in_tol(input logic [PERIOD_W-1:0] meas,
                                   input logic [PERIOD_W-1:0] ref_p);
      logic [PERIOD_W-1:0] diff;
      diff = (meas > ref_p) ? meas - ref_p : ref_p - meas;
      return diff <= (ref_p >> LOCK_SHIFT);
   endfunction : in_tol

   // link clock domain: divide the reference into one toggle per period
   logic rst_ref;
   logic [REF_DIV_W-1:0] ref_div_reg;
   logic [REF_DIV_W-1:0] ref_div_next;
   logic ref_tog_reg;
   logic ref_tog_next;

   mmci_sync #(.WIDTH(1), .INIT(1'b1)) u_rst_sync (
      .clk(MOTOR_REF_CLK),
      .rst(1'b0),
      .d(RST),
      .q(rst_ref)
   );

   always_comb begin
      ref_div_next = ref_div_reg + 16'h0001;
      ref_tog_next = ref_tog_reg;
      if (ref_div_reg >= REF_DIV - 16'h0001) begin
         ref_div_next = REF_DIV_RESET;
         ref_tog_next = !ref_tog_reg;
      end
   end

   always_ff @(posedge MOTOR_REF_CLK) begin
      if (rst_ref) begin
         ref_div_reg <= REF_DIV_RESET;
         ref_tog_reg <= 1'b0;
      end else begin
         ref_div_reg <= ref_div_next;
         ref_tog_reg <= ref_tog_next;
      end
   end

   // system domain: synchronise pins and the reference toggle
   mmci_ctrl_s ctrl;
   logic ref_tog_sync;

   mmci_sync #(.WIDTH(6), .INIT(CTRL_RESET)) u_pin_sync (
      .clk(CLK),
      .rst(RST),
      .d({MOTOR_RUN_N, MOTOR_DIR_SEL, MOTOR_BRAKE_N, HALL}),
      .q(ctrl)
   );

   mmci_sync #(.WIDTH(1), .INIT(1'b0)) u_ref_sync (
      .clk(CLK),
      .rst(RST),
      .d(ref_tog_reg),
      .q(ref_tog_sync)
   );

   mmci_state_e state_reg, state_next;
   logic ref_prev_reg, ref_prev_next;
   logic hall_a_prev_reg, hall_a_prev_next;
   logic [PERIOD_W-1:0] fg_cnt_reg, fg_cnt_next;
   logic [PERIOD_W-1:0] ref_cnt_reg, ref_cnt_next;
   logic [PERIOD_W-1:0] ref_period_reg, ref_period_next;
   logic signed [PHASE_W-1:0] phase_reg, phase_next;
   logic [DUTY_W-1:0] duty_reg, duty_next;
   logic [DUTY_W-1:0] pwm_reg, pwm_next;
   logic [LOCK_W-1:0] lock_reg, lock_next;
   mmci_gate_s gate_reg, gate_next;
   logic locked_n_reg, locked_n_next;
   logic fg_pulse_reg, fg_pulse_next;
   logic fg_evt;
   logic ref_evt;
   logic stalled;

   always_comb begin
      fg_evt = ctrl.hall[2] != hall_a_prev_reg;
      ref_evt = ref_tog_sync != ref_prev_reg;
      stalled = fg_cnt_reg == PERIOD_MAX;
      hall_a_prev_next = ctrl.hall[2];
      ref_prev_next = ref_tog_sync;
      fg_pulse_next = fg_evt;
      pwm_next = pwm_reg + 8'h01;
      phase_next = phase_reg;
      duty_next = duty_reg;
      lock_next = lock_reg;
      // brake outranks run
      if (!ctrl.brake_n) begin
         state_next = MMCI_BRAKE;
      end else if (!ctrl.run_n) begin
         state_next = MMCI_RUN;
      end else begin
         state_next = MMCI_STOP;
      end
      // period measurement of feedback and reference
      fg_cnt_next = fg_evt ? '0 : (stalled ? PERIOD_MAX : fg_cnt_reg + 20'h00001);
      ref_cnt_next = ref_evt ? '0 :
                     ((ref_cnt_reg == PERIOD_MAX) ? PERIOD_MAX : ref_cnt_reg + 20'h00001);
      ref_period_next = ref_evt ? ref_cnt_reg : ref_period_reg;
      case (state_reg)
         MMCI_RUN: begin
            // phase: reference periods ahead of feedback periods
            if (ref_evt && !fg_evt && phase_reg != PHASE_HI) begin
               phase_next = phase_reg + 4'sh1;
            end else if (fg_evt && !ref_evt && phase_reg != PHASE_LO) begin
               phase_next = phase_reg - 4'sh1;
            end
            // speed and phase correction once per feedback edge
            if (stalled && duty_reg < DUTY_START) begin
               duty_next = DUTY_START;
            end else if (fg_evt) begin
               if ((fg_cnt_reg > ref_period_reg || phase_reg > PHASE_RESET)
                   && duty_reg != DUTY_MAX) begin
                  duty_next = duty_reg + 8'h01;
               end else if ((fg_cnt_reg < ref_period_reg || phase_reg < PHASE_RESET)
                            && duty_reg != DUTY_MIN) begin
                  duty_next = duty_reg - 8'h01;
               end
            end
            // lock needs several consecutive periods in tolerance
            if (stalled
                || (fg_cnt_reg > ref_period_reg && !in_tol(fg_cnt_reg, ref_period_reg))) begin
               lock_next = LOCK_RESET;
            end else if (fg_evt) begin
               if (!in_tol(fg_cnt_reg, ref_period_reg)) begin
                  lock_next = LOCK_RESET;
               end else if (lock_reg != LOCK_COUNT) begin
                  lock_next = lock_reg + 4'h1;
               end
            end
            gate_next = commutate(ctrl.hall, ctrl.dir_sel, pwm_reg < duty_reg);
         end
         MMCI_BRAKE: begin
            // low sides short the windings; high sides stay off so no shoot-through
            phase_next = PHASE_RESET;
            duty_next = DUTY_RESET;
            lock_next = LOCK_RESET;
            gate_next = GATE_BRAKE;
         end
         MMCI_STOP: begin
            phase_next = PHASE_RESET;
            duty_next = DUTY_RESET;
            lock_next = LOCK_RESET;
            gate_next = GATE_OFF;
         end
         default: begin
            phase_next = PHASE_RESET;
            duty_next = DUTY_RESET;
            lock_next = LOCK_RESET;
            gate_next = GATE_OFF;
         end
      endcase
      // a state change passes one cycle with all switches open
      if (state_next != state_reg) begin
         gate_next = GATE_OFF;
      end
      locked_n_next = !(lock_next == LOCK_COUNT);
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         state_reg <= MMCI_STOP;
         ref_prev_reg <= 1'b0;
         hall_a_prev_reg <= 1'b0;
         fg_cnt_reg <= PERIOD_RESET;
         ref_cnt_reg <= PERIOD_RESET;
         ref_period_reg <= PERIOD_RESET;
         phase_reg <= PHASE_RESET;
         duty_reg <= DUTY_RESET;
         pwm_reg <= DUTY_RESET;
         lock_reg <= LOCK_RESET;
         gate_reg <= GATE_OFF;
         locked_n_reg <= 1'b1;
         fg_pulse_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ref_prev_reg <= ref_prev_next;
         hall_a_prev_reg <= hall_a_prev_next;
         fg_cnt_reg <= fg_cnt_next;
         ref_cnt_reg <= ref_cnt_next;
         ref_period_reg <= ref_period_next;
         phase_reg <= phase_next;
         duty_reg <= duty_next;
         pwm_reg <= pwm_next;
         lock_reg <= lock_next;
         gate_reg <= gate_next;
         locked_n_reg <= locked_n_next;
         fg_pulse_reg <= fg_pulse_next;
      end
   end

   assign GATE = gate_reg;
   assign MOTOR_LOCKED_N = locked_n_reg;
   assign SPEED_FEEDBACK_PULSE = fg_pulse_reg;
endmodule : mmci_top

// *** testbench/mmci_top_sva.sv ***
/*
 mmci_top_sva: port checks of the main motor drive logic.
 assumes: bound to mmci_top; pins are held for several CLK between changes.
*/
module mmci_top_sva
   import mmci_pkg::*;
(
   // clocks and reset
   input wire logic CLK,
   input wire logic RST,
   input wire logic MOTOR_REF_CLK,
   // pins in
   input wire logic MOTOR_RUN_N,
   input wire logic MOTOR_DIR_SEL,
   input wire logic MOTOR_BRAKE_N,
   input wire logic [2:0] HALL,
   // pins out
   input wire mmci_gate_s GATE,
   input wire logic MOTOR_LOCKED_N,
   input wire logic SPEED_FEEDBACK_PULSE
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   logic spin;
   // six samples cover two sync stages, the state register and the dead cycle
   assign spin = !MOTOR_RUN_N && MOTOR_BRAKE_N;
   chk_stop_idle: assert property ((MOTOR_RUN_N && MOTOR_BRAKE_N) [*6] |-> GATE == GATE_OFF)
      else $error("gate driven while stopped");
   chk_brake_lows: assert property ((!MOTOR_BRAKE_N) [*6] |-> GATE == GATE_BRAKE)
      else $error("brake drive wrong");
   chk_fwd_legs: assert property ((spin && !MOTOR_DIR_SEL && HALL == 3'h5) [*6] |->
      GATE.b_lo && !GATE.a_lo && !GATE.c_lo && !GATE.b_hi && !GATE.c_hi)
      else $error("forward legs wrong");
   chk_rev_legs: assert property ((spin && MOTOR_DIR_SEL && HALL == 3'h5) [*6] |->
      GATE.a_lo && !GATE.b_lo && !GATE.c_lo && !GATE.a_hi && !GATE.c_hi)
      else $error("reverse legs wrong");
   chk_bad_hall: assert property ((spin && (HALL == 3'h0 || HALL == 3'h7)) [*6] |->
      GATE == GATE_OFF)
      else $error("drive on invalid hall code");
   chk_fb_pulse: assert property ($changed(HALL[2]) |-> ##[2:4] SPEED_FEEDBACK_PULSE)
      else $error("feedback pulse missing");
   chk_fb_single: assert property (SPEED_FEEDBACK_PULSE |=> !SPEED_FEEDBACK_PULSE)
      else $error("feedback pulse too long");
   chk_lock_stop: assert property (MOTOR_RUN_N [*6] |-> MOTOR_LOCKED_N)
      else $error("lock shown while stopped");
   // both switches of one leg closed would short the supply
   chk_no_shoot: assert property (!(GATE.a_hi && GATE.a_lo) && !(GATE.b_hi && GATE.b_lo)
      && !(GATE.c_hi && GATE.c_lo))
      else $error("high and low side of one leg on together");
   cov_chop: cover property (GATE.a_hi || GATE.b_hi || GATE.c_hi);
   cov_locked: cover property ($fell(MOTOR_LOCKED_N));
   cov_brake: cover property (GATE == GATE_BRAKE);
   cov_pulse: cover property (SPEED_FEEDBACK_PULSE);
endmodule : mmci_top_sva

bind mmci_top mmci_top_sva mmci_top_sva_i (.CLK(CLK), .RST(RST), .MOTOR_REF_CLK(MOTOR_REF_CLK),
   .MOTOR_RUN_N(MOTOR_RUN_N), .MOTOR_DIR_SEL(MOTOR_DIR_SEL), .MOTOR_BRAKE_N(MOTOR_BRAKE_N),
   .HALL(HALL), .GATE(GATE), .MOTOR_LOCKED_N(MOTOR_LOCKED_N),
   .SPEED_FEEDBACK_PULSE(SPEED_FEEDBACK_PULSE));

// *** testbench/mmci_ctrl_model.sv ***
/*
 mmci_ctrl_model: controller side: reference clock and lock status input.
 assumes: run, direction and brake come from the bench tasks.
*/
module mmci_ctrl_model (
   // controller clock and reset
   input wire logic clk,
   input wire logic rst,
   // reference clock out
   output logic ref_clk,
   // lock status in and its synchronised copy
   input wire logic locked_n_in,
   output logic locked_sync_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic meta_reg;
   // free running: a gap would read as a speed error
   initial begin
      ref_clk = 1'b0;
      #7;
      forever #62.5 ref_clk = ~ref_clk;
   end
   // the lock pin is asynchronous to clk
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= 1'b1;
         locked_sync_n <= 1'b1;
      end else begin
         meta_reg <= locked_n_in;
         locked_sync_n <= meta_reg;
      end
   end
endmodule : mmci_ctrl_model

// *** testbench/tb_mmci_top.sv ***
/*
 tb_mmci_top: directed tests of brake, commutation, feedback pulse and lock.
 assumes: REF_DIV of 16'h0010 gives a reference period of 80 CLK.
*/
module tb_mmci_top
   import mmci_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int LIMIT = 4000;
   logic CLK, RST, run_n, dir_sel, brake_n, ref_clk, locked_n, fb, locked_sync_n;
   logic [2:0] hall;
   logic [2:0] seq [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
   mmci_gate_s gate;
   int failures, checks, cycles, pulses, p0;
   mmci_top #(.REF_DIV(16'h0010)) mmci_top_i (.CLK(CLK), .RST(RST), .MOTOR_REF_CLK(ref_clk),
      .MOTOR_RUN_N(run_n), .MOTOR_DIR_SEL(dir_sel), .MOTOR_BRAKE_N(brake_n), .HALL(hall),
      .GATE(gate), .MOTOR_LOCKED_N(locked_n), .SPEED_FEEDBACK_PULSE(fb));
   mmci_ctrl_model mmci_ctrl_model_i (.clk(CLK), .rst(RST), .ref_clk(ref_clk),
      .locked_n_in(locked_n), .locked_sync_n(locked_sync_n));
   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end
   task automatic conclude();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude
   task automatic check(input string what, input logic [5:0] seen, input logic [5:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wait_clk(input int n);
      repeat (n) @(posedge CLK);
   endtask : wait_clk
   // steps the rotor forward; gap is CLK per hall step
   task automatic spin(input int steps, input int gap);
      for (int i = 0; i < steps; i++) begin
         wait_clk(gap);
         hall <= seq[i % 6];
      end
   endtask : spin
   // {high side mask, low side mask} expected for a hall code
   function automatic logic [11:0] legs(input logic [2:0] h, input logic d);
      logic [1:0] hi, lo;
      case (h)
         3'h5: {hi, lo} = 4'h9;
         3'h4: {hi, lo} = 4'h8;
         3'h6: {hi, lo} = 4'h4;
         3'h2: {hi, lo} = 4'h6;
         3'h3: {hi, lo} = 4'h2;
         3'h1: {hi, lo} = 4'h1;
         default: return 12'h000;
      endcase
      if (d) {hi, lo} = {lo, hi};
      return {6'h02 << (2 * hi), 6'h01 << (2 * lo)};
   endfunction : legs
   always @(posedge CLK) begin
      if (fb === 1'b1) pulses++;
   end
   always @(posedge CLK) begin
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         conclude();
      end
   end
   initial begin
      logic [11:0] m;
      RST = 1'b1;
      run_n = 1'b1;
      dir_sel = 1'b0;
      brake_n = 1'b1;
      hall = 3'h5;
      // long enough for the reference domain to see reset too
      wait_clk(16);
      RST <= 1'b0;
      wait_clk(1);
      check("gate idle", gate, 6'h00);
      check("lock idle", {5'h00, locked_n}, 6'h01);
      brake_n <= 1'b0;
      run_n <= 1'b0;
      wait_clk(6);
      check("brake over run", gate, GATE_BRAKE);
      brake_n <= 1'b1;
      for (int d = 0; d < 2; d++) begin
         dir_sel <= d[0];
         for (int k = 0; k < 8; k++) begin
            hall <= k[2:0];
            wait_clk(6);
            m = legs(k[2:0], d[0]);
            check("legs", gate & ~m[11:6], m[5:0]);
         end
      end
      dir_sel <= 1'b0;
      p0 = pulses;
      spin(48, 28);
      wait_clk(4);
      check("lock at 84", {5'h00, locked_sync_n}, 6'h00);
      check("pulses", 6'(pulses - p0), 6'h0F);
      spin(9, 30);
      check("lock at 90", {5'h00, locked_sync_n}, 6'h01);
      run_n <= 1'b1;
      wait_clk(6);
      check("stop", gate, GATE_OFF);
      conclude();
   end
endmodule : tb_mmci_top
